//--- rsq_pkg.sv
package rsq_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_POR_DELAY_MS = 10;
  localparam int unsigned T_RELEASE_US = 200;
  localparam int unsigned T_EXT_LOW_US = 15;
  localparam int unsigned T_MCD_US = 80;
  localparam int unsigned T_MON_ON_US = 100;

  // least times round up, longest times round down
  localparam int unsigned POR_DELAY_CYC =
    T_POR_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_CYC = T_RELEASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned EXT_LOW_CYC =
    (T_EXT_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MCD_CYC =
    (T_MCD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MON_ON_CYC =
    (T_MON_ON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [2:0] SUP_TMR_INTERVAL_MAX = 3'h7;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic por;
    logic ext_pin;
    logic comparator;
    logic software;
    logic supply_mon;
    logic sup_timer;
    logic missing_clk;
    logic flash_err;
    logic usb;
  } rsq_src_t;

  typedef enum logic [1:0] {
    RSQ_ACTIVE,
    RSQ_DELAY,
    RSQ_RUN
  } rsq_state_t;

endpackage

//--- rsq_counter.sv
`timescale 1ns/1ns
`default_nettype none
// saturating up-counter with a run-time threshold
module rsq_counter #(
  parameter int unsigned W = 17
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic inc_i,
  input wire logic [W-1:0] limit_i,
  output logic reached_o
);

  logic [W-1:0] cnt;

  // ------------------------------------------------------------
  // threshold compare
  // ------------------------------------------------------------
  assign reached_o = (cnt >= limit_i);

  // ------------------------------------------------------------
  // count, held at the limit so it never wraps back to zero
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        cnt <= '0;
      end else if (inc_i && !reached_o) begin
        cnt <= cnt + W'(1);
      end
    end
  end

endmodule
`default_nettype wire

//--- rsq_reset_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module rsq_reset_sequencer #(
  parameter int unsigned CNT_W = 17,
  parameter int unsigned POR_DELAY_CYCLES = rsq_pkg::POR_DELAY_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic vdd_above_por_i,
  input wire logic external_reset_pin_n_i,
  input wire logic comparator_reset_i,
  input wire logic comparator_reset_en_i,
  input wire logic sw_reset_req_i,
  input wire logic supply_mon_en_i,
  input wire logic supply_low_i,
  input wire logic supervision_timer_ovf_i,
  input wire logic mcd_en_i,
  input wire logic sysclk_mon_i,
  input wire logic flash_error_i,
  input wire logic usb_reset_i,
  input wire logic supervision_timer_disable_i,
  input wire logic supervision_timer_interval_wr_i,
  input wire logic [2:0] supervision_timer_interval_i,
  input wire logic clk_sel_wr_i,
  input wire logic clk_sel_ext_i,
  input wire logic pullup_disable_i,
  output logic core_halt_o,
  output logic reg_reset_o,
  output logic por_reg_reset_o,
  output logic port_force_od_high_o,
  output logic irq_timer_disable_o,
  output logic ram_write_block_o,
  output logic weak_pullup_en_o,
  output logic external_reset_pin_n_o,
  output logic external_reset_pin_n_oe_o,
  output logic pc_clear_o,
  output logic [15:0] fetch_addr_o,
  output logic core_start_o,
  output logic clk_sel_internal_o,
  output logic supervision_timer_en_o,
  output logic [2:0] supervision_timer_interval_o,
  output rsq_pkg::rsq_src_t reset_cause_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (POR_DELAY_CYCLES < 1 || POR_DELAY_CYCLES >= (1 << CNT_W)) begin : g_chk_por
    $error("POR_DELAY_CYCLES does not fit CNT_W");
  end
  if (rsq_pkg::RELEASE_CYC >= (1 << CNT_W) ||
      rsq_pkg::MON_ON_CYC >= (1 << CNT_W) ||
      rsq_pkg::MCD_CYC >= (1 << CNT_W)) begin : g_chk_w
    $error("CNT_W too narrow for timing counts");
  end

  rsq_pkg::rsq_state_t state;
  rsq_pkg::rsq_state_t next_state;
  rsq_pkg::rsq_src_t src;
  logic por_seen;
  logic drive_pin;
  logic clk_prev;
  logic mcd_armed;
  logic any_src;
  logic ext_low;
  logic ext_reached;
  logic mon_valid;
  logic mcd_reached;
  logic mcd_fire;
  logic clk_edge;
  logic delay_done;
  logic [CNT_W-1:0] delay_limit;
  logic next_run;
  logic leaving;

  // ------------------------------------------------------------
  // external pin qualifier
  // ------------------------------------------------------------
  // ignore the pin while we drive it, or our own drive would retrigger
  assign ext_low = !external_reset_pin_n_i && !external_reset_pin_n_oe_o;

  rsq_counter #(
    .W(CNT_W)
  ) u_ext_filt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(!ext_low),
    .inc_i(1'b1),
    .limit_i(CNT_W'(rsq_pkg::EXT_LOW_CYC)),
    .reached_o(ext_reached)
  );

  // ------------------------------------------------------------
  // supply monitor turn-on blanking
  // ------------------------------------------------------------
  rsq_counter #(
    .W(CNT_W)
  ) u_mon_blank (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(!supply_mon_en_i),
    .inc_i(1'b1),
    .limit_i(CNT_W'(rsq_pkg::MON_ON_CYC)),
    .reached_o(mon_valid)
  );

  // ------------------------------------------------------------
  // missing clock detector
  // ------------------------------------------------------------
  // arms only after a first edge, so a clock never started is not flagged
  assign clk_edge = (sysclk_mon_i != clk_prev);

  rsq_counter #(
    .W(CNT_W)
  ) u_mcd (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(clk_edge || !mcd_armed),
    .inc_i(1'b1),
    .limit_i(CNT_W'(rsq_pkg::MCD_CYC)),
    .reached_o(mcd_reached)
  );

  assign mcd_fire = mcd_en_i && mcd_armed && mcd_reached;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clk_prev <= 1'b0;
      mcd_armed <= 1'b0;
    end else if (ce_i) begin
      clk_prev <= sysclk_mon_i;
      mcd_armed <= mcd_en_i && (mcd_armed || clk_edge);
    end
  end

  // ------------------------------------------------------------
  // source merge
  // ------------------------------------------------------------
  assign src.por = !vdd_above_por_i;
  assign src.ext_pin = ext_reached;
  assign src.comparator = comparator_reset_en_i && comparator_reset_i;
  assign src.software = sw_reset_req_i;
  assign src.supply_mon = supply_mon_en_i && mon_valid && supply_low_i;
  assign src.sup_timer = supervision_timer_ovf_i;
  assign src.missing_clk = mcd_fire;
  assign src.flash_err = flash_error_i;
  assign src.usb = usb_reset_i;
  assign any_src = |src;

  // ------------------------------------------------------------
  // release delay
  // ------------------------------------------------------------
  // power-on gets the long hold, every other source the short one
  assign delay_limit = por_seen ? CNT_W'(POR_DELAY_CYCLES)
                                : CNT_W'(rsq_pkg::RELEASE_CYC);

  rsq_counter #(
    .W(CNT_W)
  ) u_delay (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(state != rsq_pkg::RSQ_DELAY),
    .inc_i(1'b1),
    .limit_i(delay_limit),
    .reached_o(delay_done)
  );

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      rsq_pkg::RSQ_ACTIVE: begin
        if (!any_src) begin
          next_state = rsq_pkg::RSQ_DELAY;
        end
      end
      rsq_pkg::RSQ_DELAY: begin
        if (any_src) begin
          next_state = rsq_pkg::RSQ_ACTIVE;
        end else if (delay_done) begin
          next_state = rsq_pkg::RSQ_RUN;
        end
      end
      rsq_pkg::RSQ_RUN: begin
        if (any_src) begin
          next_state = rsq_pkg::RSQ_ACTIVE;
        end
      end
      default: next_state = rsq_pkg::RSQ_ACTIVE;
    endcase
  end

  assign next_run = (next_state == rsq_pkg::RSQ_RUN);
  assign leaving = next_run && (state != rsq_pkg::RSQ_RUN);

  // ------------------------------------------------------------
  // state and reset bookkeeping
  // ------------------------------------------------------------
  // sequencer reset counts as power-on: long hold, pin driven
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= rsq_pkg::RSQ_ACTIVE;
      por_seen <= 1'b1;
      drive_pin <= 1'b1;
    end else if (ce_i) begin
      state <= next_state;
      por_seen <= !next_run && (por_seen || src.por);
      drive_pin <= !next_run && (drive_pin || src.por || src.supply_mon);
    end
  end

  // ------------------------------------------------------------
  // reset cause record
  // ------------------------------------------------------------
  // cleared on a new entry from run, accumulates while in reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reset_cause_o <= '0;
    end else if (ce_i) begin
      if (state == rsq_pkg::RSQ_RUN && any_src) begin
        reset_cause_o <= src;
      end else if (state != rsq_pkg::RSQ_RUN) begin
        reset_cause_o <= reset_cause_o | src;
      end
    end
  end

  // ------------------------------------------------------------
  // reset-state outputs
  // ------------------------------------------------------------
  // all taken from next_state so they line up with the state register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      core_halt_o <= 1'b1;
      reg_reset_o <= 1'b1;
      por_reg_reset_o <= 1'b1;
      port_force_od_high_o <= 1'b1;
      irq_timer_disable_o <= 1'b1;
      pc_clear_o <= 1'b1;
      core_start_o <= 1'b0;
    end else if (ce_i) begin
      core_halt_o <= !next_run;
      reg_reset_o <= !next_run;
      // power-on-only bits clear only on a power-on reset
      por_reg_reset_o <= !next_run && (por_seen || src.por);
      port_force_od_high_o <= !next_run;
      irq_timer_disable_o <= !next_run;
      pc_clear_o <= !next_run;
      core_start_o <= leaving;
    end
  end

  // ------------------------------------------------------------
  // pin drive and fixed vector
  // ------------------------------------------------------------
  // RAM has no reset path; writes are only blocked while halted
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      external_reset_pin_n_o <= 1'b0;
      external_reset_pin_n_oe_o <= 1'b1;
      ram_write_block_o <= 1'b1;
      fetch_addr_o <= rsq_pkg::RESET_VECTOR;
    end else if (ce_i) begin
      external_reset_pin_n_o <= 1'b0; // only ever pulls low
      external_reset_pin_n_oe_o <= !next_run &&
        (drive_pin || src.por || src.supply_mon);
      ram_write_block_o <= !next_run;
      fetch_addr_o <= rsq_pkg::RESET_VECTOR;
    end
  end

  // ------------------------------------------------------------
  // post-reset defaults that software may later change
  // ------------------------------------------------------------
  // software changes are honoured only in run, reset forces defaults
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      weak_pullup_en_o <= 1'b1;
      clk_sel_internal_o <= 1'b1;
      supervision_timer_en_o <= 1'b1;
      supervision_timer_interval_o <= rsq_pkg::SUP_TMR_INTERVAL_MAX;
    end else if (ce_i) begin
      if (!next_run) begin
        weak_pullup_en_o <= 1'b1;
        clk_sel_internal_o <= 1'b1;
        supervision_timer_en_o <= 1'b1;
        supervision_timer_interval_o <= rsq_pkg::SUP_TMR_INTERVAL_MAX;
      end else if (state == rsq_pkg::RSQ_RUN) begin
        if (pullup_disable_i) begin
          weak_pullup_en_o <= 1'b0;
        end
        if (clk_sel_wr_i) begin
          clk_sel_internal_o <= !clk_sel_ext_i;
        end
        if (supervision_timer_disable_i) begin
          supervision_timer_en_o <= 1'b0;
        end
        if (supervision_timer_interval_wr_i) begin
          supervision_timer_interval_o <= supervision_timer_interval_i;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- rsq_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// far side: supply rail and reset pin
// ----
module rsq_partner (
  input wire logic mclk_i,
  input wire logic vdd_ok_i,
  input wire logic pin_req_i,
  input wire logic dut_oe_i,
  output logic vdd_above_por_o,
  output logic pin_n_o
);
  // starts at zero so an idle pin reads high from the very first cycle
  int unsigned hold = 0;
  logic pulling;
  // a request keeps the pin low the minimum time, with margin
  always @(posedge mclk_i) begin
    if (pin_req_i) hold <= rsq_pkg::EXT_LOW_CYC + 5;
    else if (hold != 0) hold <= hold - 1;
  end
  // pull-up on the pin: nobody pulling reads high
  assign pulling = pin_req_i || hold != 0;
  assign pin_n_o = !(dut_oe_i || pulling);
  assign vdd_above_por_o = vdd_ok_i;
endmodule
`default_nettype wire

//--- rsq_reset_sequencer_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// port checker
// ----
module rsq_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sw_reset_req_i,
  input wire logic core_halt_o,
  input wire logic reg_reset_o,
  input wire logic port_force_od_high_o,
  input wire logic irq_timer_disable_o,
  input wire logic ram_write_block_o,
  input wire logic pc_clear_o,
  input wire logic weak_pullup_en_o,
  input wire logic external_reset_pin_n_oe_o,
  input wire logic [15:0] fetch_addr_o,
  input wire logic core_start_o,
  input wire logic clk_sel_internal_o,
  input wire logic supervision_timer_en_o,
  input wire logic [2:0] supervision_timer_interval_o,
  input wire rsq_pkg::rsq_src_t reset_cause_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [11:0] held;
  // cycles in reset since the software source let go, saturating
  always_ff @(posedge mclk_i) begin
    if (rst_i || !core_halt_o || sw_reset_req_i) held <= 12'h000;
    else if (held != 12'hFFF) held <= held + 12'h001;
  end
  AST_HOLD_OUTS: assert property (core_halt_o |->
    reg_reset_o && port_force_od_high_o && irq_timer_disable_o &&
    ram_write_block_o && pc_clear_o) else $error("reset outputs low");
  AST_SW_ENTRY: assert property (!core_halt_o && sw_reset_req_i
    |=> core_halt_o && reset_cause_o.software) else $error("no entry");
  AST_SRC_HOLD: assert property (core_halt_o && sw_reset_req_i
    |=> core_halt_o) else $error("left reset with source up");
  AST_START: assert property ($fell(core_halt_o) |->
    core_start_o && fetch_addr_o == 16'h0000 ##1 !core_start_o)
    else $error("bad exit pulse");
  AST_EXIT_CFG: assert property (core_start_o |->
    clk_sel_internal_o && supervision_timer_en_o && weak_pullup_en_o &&
    supervision_timer_interval_o == 3'h7) else $error("bad exit setup");
  AST_PIN_DRIVE: assert property (core_halt_o &&
    (reset_cause_o.por || reset_cause_o.supply_mon)
    |-> external_reset_pin_n_oe_o) else $error("pin not driven");
  AST_PIN_TMR: assert property (reset_cause_o == 9'h008
    |-> !external_reset_pin_n_oe_o) else $error("timer drove pin");
  AST_SW_TIME: assert property (core_halt_o &&
    reset_cause_o == 9'h020 |-> held < 12'h9C4) else $error("slow exit");
  cover property (core_start_o);
  cover property (core_halt_o && reset_cause_o.por);
  cover property (core_halt_o && reset_cause_o.missing_clk);
endmodule
`default_nettype wire

//--- system_reset_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// testbench
// ----
module system_reset_sequencer_test;
  localparam int unsigned PORD = 20;
  logic mclk_i, rst_i, ce_i, vdd_above_por_i, external_reset_pin_n_i;
  logic comparator_reset_i, comparator_reset_en_i, sw_reset_req_i;
  logic supply_mon_en_i, supply_low_i, supervision_timer_ovf_i, mcd_en_i;
  logic sysclk_mon_i, flash_error_i, usb_reset_i, clk_sel_wr_i;
  logic supervision_timer_disable_i, supervision_timer_interval_wr_i;
  logic [2:0] supervision_timer_interval_i, supervision_timer_interval_o;
  logic clk_sel_ext_i, pullup_disable_i, core_halt_o, reg_reset_o;
  logic por_reg_reset_o, port_force_od_high_o, irq_timer_disable_o;
  logic ram_write_block_o, weak_pullup_en_o, external_reset_pin_n_o;
  logic external_reset_pin_n_oe_o, pc_clear_o, core_start_o;
  logic clk_sel_internal_o, supervision_timer_en_o, vdd_ok, pin_req, mrun;
  logic [15:0] fetch_addr_o;
  rsq_pkg::rsq_src_t reset_cause_o;
  int err_count, samples_checked, n, len, r;
  rsq_reset_sequencer #(.POR_DELAY_CYCLES(PORD)) DUT (.mclk_i, .rst_i,
    .ce_i, .vdd_above_por_i, .external_reset_pin_n_i, .comparator_reset_i,
    .comparator_reset_en_i, .sw_reset_req_i, .supply_mon_en_i,
    .supply_low_i, .supervision_timer_ovf_i, .mcd_en_i, .sysclk_mon_i,
    .flash_error_i, .usb_reset_i, .supervision_timer_disable_i,
    .supervision_timer_interval_wr_i, .supervision_timer_interval_i,
    .clk_sel_wr_i, .clk_sel_ext_i, .pullup_disable_i, .core_halt_o,
    .reg_reset_o, .por_reg_reset_o, .port_force_od_high_o,
    .irq_timer_disable_o, .ram_write_block_o, .weak_pullup_en_o,
    .external_reset_pin_n_o, .external_reset_pin_n_oe_o, .pc_clear_o,
    .fetch_addr_o, .core_start_o, .clk_sel_internal_o,
    .supervision_timer_en_o, .supervision_timer_interval_o, .reset_cause_o);
  rsq_partner u_far (.mclk_i, .vdd_ok_i(vdd_ok), .pin_req_i(pin_req),
    .dut_oe_i(external_reset_pin_n_oe_o), .vdd_above_por_o(vdd_above_por_i),
    .pin_n_o(external_reset_pin_n_i));
  always #50 mclk_i = ~mclk_i;
  // monitored clock toggles while mrun is set, stops to provoke the detector
  always @(posedge mclk_i) if (mrun) sysclk_mon_i <= ~sysclk_mon_i;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  // bounded waits; count cycles taken
  task automatic wait_halt();
    n = 0;
    while (core_halt_o !== 1'h1 && n < 9000) begin step(1); n++; end
  endtask
  task automatic wait_start();
    n = 0;
    while (core_start_o !== 1'h1 && n < 40000) begin step(1); n++; end
  endtask
  task automatic exit_state();
    chk({clk_sel_internal_o, supervision_timer_en_o, weak_pullup_en_o,
      supervision_timer_interval_o}, 16'h003F);
    chk(fetch_addr_o, 16'h0000);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    // about twice the cycles the scenarios need
    #5000000;
    err_count++;
    final_report();
  end
  initial begin
    r = $urandom(80347);
    // reset high, clock enabled, supply good, pin idle, monitor clock still
    {mclk_i, rst_i, ce_i, vdd_ok, pin_req, mrun, sysclk_mon_i} = 7'h38;
    {comparator_reset_i, comparator_reset_en_i, sw_reset_req_i} = 3'h2;
    {supply_mon_en_i, supply_low_i, supervision_timer_ovf_i} = 3'h0;
    {mcd_en_i, flash_error_i, usb_reset_i, clk_sel_wr_i} = 4'h0;
    {supervision_timer_disable_i, supervision_timer_interval_wr_i} = 2'h0;
    {clk_sel_ext_i, pullup_disable_i} = 2'h0;
    supervision_timer_interval_i = 3'h0;
    step(20);
    rst_i = 1'h0;
    chk(core_halt_o, 1'h1);
    wait_start();
    chk(n >= PORD, 1'h1);
    exit_state();
    // monitor output not trusted right after switch-on
    {supply_mon_en_i, supply_low_i} = 2'h3;
    step(20);
    chk(core_halt_o, 1'h0);
    supply_low_i = 1'h0;
    step(1000);
    for (int k = 0; k < 9; k++) begin
      // run-time settings that the next reset must undo
      {clk_sel_wr_i, clk_sel_ext_i, supervision_timer_interval_wr_i} = '1;
      {supervision_timer_disable_i, pullup_disable_i} = 2'h3;
      supervision_timer_interval_i = 3'($urandom_range(0, 6));
      mcd_en_i = (k == 6);
      mrun = (k == 6);
      step(1);
      {clk_sel_wr_i, supervision_timer_interval_wr_i} = 2'h0;
      {supervision_timer_disable_i, pullup_disable_i} = 2'h0;
      chk({clk_sel_internal_o, supervision_timer_en_o, weak_pullup_en_o,
        supervision_timer_interval_o}, {13'h0, supervision_timer_interval_i});
      step(10);
      len = k == 5 ? 1 : int'($urandom_range(1, 8));
      case (k)
        0: vdd_ok = 1'h0;
        1: pin_req = 1'h1;
        2: comparator_reset_i = 1'h1;
        3: sw_reset_req_i = 1'h1;
        4: supply_low_i = 1'h1;
        5: supervision_timer_ovf_i = 1'h1;
        6: mrun = 1'h0;
        7: flash_error_i = 1'h1;
        default: usb_reset_i = 1'h1;
      endcase
      step(len);
      {pin_req, comparator_reset_i, sw_reset_req_i, supply_low_i} = 4'h0;
      {supervision_timer_ovf_i, flash_error_i, usb_reset_i} = 3'h0;
      vdd_ok = 1'h1;
      wait_halt();
      if (k == 6) chk(n + len >= 800 && n + len <= 8000, 1'h1);
      mcd_en_i = 1'h0;
      chk(reset_cause_o, 16'(9'h100 >> k));
      chk({external_reset_pin_n_oe_o, por_reg_reset_o},
        {k == 0 || k == 4, k == 0});
      chk(external_reset_pin_n_o, 1'h0);
      wait_start();
      if (k > 1 && k != 6) chk(n <= 2500, 1'h1);
      exit_state();
    end
    // a held source keeps reset past the normal release delay
    sw_reset_req_i = 1'h1;
    step(2600);
    chk(core_halt_o, 1'h1);
    sw_reset_req_i = 1'h0;
    wait_start();
    chk(n <= 2500, 1'h1);
    final_report();
  end
endmodule
bind rsq_reset_sequencer rsq_chk u_chk (.mclk_i, .rst_i, .sw_reset_req_i,
  .core_halt_o, .reg_reset_o, .port_force_od_high_o, .irq_timer_disable_o,
  .ram_write_block_o, .pc_clear_o, .weak_pullup_en_o,
  .external_reset_pin_n_oe_o, .fetch_addr_o, .core_start_o,
  .clk_sel_internal_o, .supervision_timer_en_o,
  .supervision_timer_interval_o, .reset_cause_o);
`default_nettype wire
